// *** nip_unit.sv ***
// Operation
// RULE1: Current level lives in flags bits 5 and 3; 10,01,00,11 is level 0..3.
// RULE2: Entering a maskable interrupt loads the vector's field into those bits.
// RULE3: Trap and reset are taken even at level 3.
// RULE4: Flags reset to 111x1010, so the core starts at level 3.
// RULE5: Four vector priority registers reset to all ones.
// RULE6: Upper four bits of the fourth register are read-only ones.
// RULE7: Vector x field sits in register x/4, bits 2*(x mod 4)+1 and below.
// RULE8: Vector fields use the same level coding as the flags bits.
// RULE9: Writing the level 0 code into a field leaves that field unchanged.
// RULE10: Top-level, reset and trap entry set both level bits.
// RULE11: The top-level field is stored but ignored by arbitration.
// RULE12: Raising a running vector's field while pending re-enters it.
// RULE13: Enable, halt and wait instructions load code 10.
// RULE14: Disable instruction and trap load code 11.
// RULE15: Return and flags pop restore both level bits from the stack.
// RULE16: Masked and unmasked jump conditions test for code 11.
// RULE17: Those instructions change the level at any time, even in a routine.
// RULE18: Fixed vector addresses descend from FFFEh; vector 6 unused; low number wins.
// RULE19: Only reset, top-level, clock and pin vectors always wake from halt.
// RULE20: Synchronous serial vector wakes from halt only in slave mode.
// RULE21: PWM timer vector wakes from halt only on external clock.
// RULE22: Highest software level first, then fixed order; losers stay latched.
// RULE23: Maskable request served only when its level is strictly above current.
// RULE24: Arbitration happens only at instruction boundaries.
`timescale 1ns/1ns
`default_nettype none
module nip_unit (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [nip_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core side
  input wire logic instr_boundary_i,
  input wire nip_pkg::nip_instr_s instr_i,
  output var nip_pkg::nip_take_s take_o,
  output logic [7:0] cpu_flags_register_o,
  output logic jump_if_masked_o,
  output logic jump_if_unmasked_o,
  output logic halted_o,
  output logic wake_o,
  // Peripheral requests and modes
  input wire logic [13:0] req_i,
  input wire logic spi_slave_i,
  input wire logic pwm_ext_clk_i
);

  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [13:0] pend_q;
  logic halted_q;
  logic wake_q;
  logic busy_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_mux;
  logic jm_q;
  nip_pkg::nip_take_s take_q;
  logic [3:0][7:0] vpri;
  logic [7:0] vpri_rd;
  logic [1:0] fld [nip_pkg::NVEC];
  logic [2:0] lvl [nip_pkg::NVEC];
  logic [13:0] wake_en;
  logic [13:0] elig;
  logic [2:0] cur_lvl;
  logic found;
  logic [3:0] win;
  logic [2:0] win_lvl;
  logic [1:0] win_fld;
  logic [1:0] code_n;
  logic code_set;
  logic irq_take;
  logic wake_now;
  logic [13:0] clr;

  // ==========================================================
  // Bus decode
  // Answer comes two cycles after the request so that read data of the
  // priority store, which is registered, can be muxed into a flop.
  wire logic req_new = wb_cyc_i & wb_stb_i & ~busy_q & ~ack_q;
  wire logic [7:0] widx = wb_adr_i[9:2];
  wire logic wr_commit = busy_q & wb_we_i & wb_sel_i[0];
  wire logic vpri_hit = widx[7:2] == nip_pkg::IDX_VPRI0[7:2];
  wire logic wr_flags = wr_commit & (widx == nip_pkg::IDX_FLAGS);
  wire logic wr_pend = wr_commit & (widx == nip_pkg::IDX_PEND);

  nip_vpri_mem u_vpri (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(wr_commit & vpri_hit),
    .idx_i(widx[1:0]),
    .wdata_i(wb_dat_i[7:0]),
    .rdata_o(vpri_rd),
    .regs_o(vpri)
  );

  always_comb begin
    case (widx)
      nip_pkg::IDX_FLAGS: rd_mux = {24'h000000, flags_q};
      nip_pkg::IDX_PEND: rd_mux = {18'h00000, pend_q};
      nip_pkg::IDX_STAT: rd_mux = {28'h0000000, halted_q, cur_lvl};
      default: rd_mux = vpri_hit ? {24'h000000, vpri_rd} : 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      busy_q <= req_new;
      ack_q <= busy_q;
      if (busy_q) begin
        dat_q <= rd_mux;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ==========================================================
  // Per-vector level, wake capability and eligibility
  assign cur_lvl = nip_pkg::code_level({flags_q[nip_pkg::FL_HI], flags_q[nip_pkg::FL_LO]}); // RULE1

  for (genvar v = 0; v < nip_pkg::NVEC; v++) begin : g_vec
    assign fld[v] = vpri[v/4][2*(v%4)+:2]; // RULE7
    // Top-level vector outranks every software level, its field is unused
    assign lvl[v] = (v == 0) ? nip_pkg::LVL_TOP : nip_pkg::code_level(fld[v]); // RULE8 RULE11
    if (v == nip_pkg::SPI_VEC) begin : g_spi
      assign wake_en[v] = spi_slave_i; // RULE20
    end else if (v == nip_pkg::PWM_VEC) begin : g_pwm
      assign wake_en[v] = pwm_ext_clk_i; // RULE21
    end else begin : g_fix
      assign wake_en[v] = nip_pkg::WAKE_ALWAYS[v]; // RULE19
    end
    // Compares against the live field, so a raised level re-enters at once
    assign elig[v] = pend_q[v] & (lvl[v] > cur_lvl) & (~halted_q | wake_en[v]); // RULE23 RULE12
  end

  // ==========================================================
  // Arbitration: strict compare keeps ties on the lower vector number
  always_comb begin
    found = 1'b0;
    win = 4'h0;
    win_lvl = 3'h0;
    for (int i = 0; i < nip_pkg::NVEC; i++) begin
      if (elig[i] && (!found || lvl[i] > win_lvl)) begin // RULE22
        found = 1'b1;
        win = 4'(i);
        win_lvl = lvl[i];
      end
    end
  end

  assign win_fld = fld[win];
  // A trap instruction owns the boundary it ends on
  assign irq_take = instr_boundary_i & found & ~instr_i.trap; // RULE24

  // ==========================================================
  // Flags register
  always_comb begin
    flags_d = flags_q;
    code_n = nip_pkg::CODE_L3;
    code_set = 1'b0;
    if (wr_flags) begin
      flags_d = wb_dat_i[7:0];
    end
    if (instr_i.ien || instr_i.halt || instr_i.wait_for_irq_instr) begin
      code_n = nip_pkg::CODE_L0; // RULE13 RULE17
      code_set = 1'b1;
    end
    if (instr_i.idis) begin
      code_n = nip_pkg::CODE_L3; // RULE14 RULE17
      code_set = 1'b1;
    end
    if (instr_i.service_return_instr || instr_i.pop) begin
      flags_d = instr_i.data; // RULE15 RULE17
      code_set = 1'b0;
    end
    if (instr_i.trap) begin
      code_n = nip_pkg::CODE_L3; // RULE14 RULE3
      code_set = 1'b1;
    end
    if (irq_take) begin
      code_n = (win == 4'h0) ? nip_pkg::CODE_L3 : win_fld; // RULE2 RULE10
      code_set = 1'b1;
    end
    if (code_set) begin
      flags_d[nip_pkg::FL_HI] = code_n[1];
      flags_d[nip_pkg::FL_LO] = code_n[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= nip_pkg::FLAGS_RST; // RULE4
      jm_q <= 1'b1;
    end else begin
      flags_q <= flags_d;
      jm_q <= flags_d[nip_pkg::FL_HI] & flags_d[nip_pkg::FL_LO]; // RULE16
    end
  end

  assign cpu_flags_register_o = flags_q;
  assign jump_if_masked_o = jm_q;
  assign jump_if_unmasked_o = ~jm_q;

  // ==========================================================
  // Pending latches
  // Set wins over both the entry clear and a software clear.
  // The unused slot can never latch.
  assign clr = (wr_pend ? wb_dat_i[13:0] : 14'h0000) | (irq_take ? (14'h0001 << win) : 14'h0000);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= 14'h0000;
    end else begin
      pend_q <= (pend_q & ~clr) | (req_i & nip_pkg::VEC_USED); // RULE22 RULE18
    end
  end

  // ==========================================================
  // Halt and wake
  // Trap cannot wake: a halted core issues no instruction.
  assign wake_now = halted_q & (|(pend_q & wake_en)); // RULE19

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      halted_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_now;
      if (instr_i.halt) begin
        halted_q <= 1'b1;
      end else if (wake_now) begin
        halted_q <= 1'b0;
      end
    end
  end

  assign halted_o = halted_q;
  assign wake_o = wake_q;

  // ==========================================================
  // Service request to the core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      take_q <= '0;
    end else begin
      take_q.vld <= instr_i.trap | irq_take;
      take_q.trap <= instr_i.trap;
      take_q.num <= instr_i.trap ? 4'h0 : win;
      take_q.addr <= instr_i.trap ? nip_pkg::ADDR_TRAP
                                  : nip_pkg::ADDR_VEC0 - {11'h000, win, 1'b0}; // RULE18
    end
  end

  assign take_o = take_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_rst_flags;
    $fell(rst_i) |-> flags_q == nip_pkg::FLAGS_RST && jump_if_masked_o;
  endproperty
  a_rst_flags: assert property (p_rst_flags) else $error("flags reset value wrong"); // RULE4

  property p_rst_vpri;
    $fell(rst_i) |-> vpri == {4{nip_pkg::VPRI_RST}};
  endproperty
  a_rst_vpri: assert property (p_rst_vpri) else $error("priority reset value wrong"); // RULE5

  property p_trap_l3;
    instr_i.trap && cur_lvl == 3'h3 |=> take_o.vld && take_o.addr == nip_pkg::ADDR_TRAP;
  endproperty
  a_trap_l3: assert property (p_trap_l3) else $error("trap blocked at level 3"); // RULE3

  property p_trap_code;
    instr_i.trap |=> flags_q[nip_pkg::FL_HI] && flags_q[nip_pkg::FL_LO];
  endproperty
  a_trap_code: assert property (p_trap_code) else $error("trap did not set level 3"); // RULE14

  property p_tli_code;
    take_o.vld && !take_o.trap && take_o.num == 4'h0 |-> flags_q[nip_pkg::FL_HI] && flags_q[nip_pkg::FL_LO];
  endproperty
  a_tli_code: assert property (p_tli_code) else $error("top-level entry not at level 3"); // RULE10

  property p_entry_load;
    take_o.vld && !take_o.trap && take_o.num != 4'h0
      |-> {flags_q[nip_pkg::FL_HI], flags_q[nip_pkg::FL_LO]} == $past(win_fld);
  endproperty
  a_entry_load: assert property (p_entry_load) else $error("entry level not loaded"); // RULE2

  property p_enable;
    instr_i.ien && !instr_i.idis && !instr_i.trap && !instr_i.service_return_instr && !instr_i.pop && !irq_take
      |=> {flags_q[nip_pkg::FL_HI], flags_q[nip_pkg::FL_LO]} == nip_pkg::CODE_L0;
  endproperty
  a_enable: assert property (p_enable) else $error("enable did not load level 0"); // RULE13

  property p_jump;
    jump_if_masked_o == (flags_q[nip_pkg::FL_HI] & flags_q[nip_pkg::FL_LO]) && jump_if_unmasked_o != jump_if_masked_o;
  endproperty
  a_jump: assert property (p_jump) else $error("jump condition disagrees with flags"); // RULE16

  property p_strict;
    take_o.vld && !take_o.trap |-> $past(win_lvl) > $past(cur_lvl);
  endproperty
  a_strict: assert property (p_strict) else $error("request taken at or below level"); // RULE23

  property p_no_wake;
    halted_q && (pend_q & wake_en) == 14'h0000 |=> !wake_o;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("wake from a source that cannot wake"); // RULE19

endmodule : nip_unit
`default_nettype wire

// *** nip_pkg.sv ***
package nip_pkg;

  // ==========================================================
  // Register map (word index, byte address is index times four)
  localparam int WB_AW = 10;
  localparam logic [7:0] IDX_FLAGS = 8'h20;
  localparam logic [7:0] IDX_PEND = 8'h21;
  localparam logic [7:0] IDX_STAT = 8'h22;
  localparam logic [7:0] IDX_VPRI0 = 8'h24;
  localparam logic [7:0] IDX_VPRI3 = 8'h27;

  // ==========================================================
  // Field positions and reset values
  localparam int FL_HI = 5;
  localparam int FL_LO = 3;
  localparam logic [7:0] FLAGS_RST = 8'hea;
  localparam logic [7:0] VPRI_RST = 8'hff;
  localparam logic [7:0] VPRI3_RO = 8'hf0;
  localparam logic [1:0] CODE_L0 = 2'b10;
  localparam logic [1:0] CODE_L3 = 2'b11;
  localparam logic [2:0] LVL_TOP = 3'h4;

  // ==========================================================
  // Vector table
  localparam int NVEC = 14;
  localparam int SPI_VEC = 7;
  localparam int PWM_VEC = 13;
  localparam logic [13:0] VEC_USED = 14'h3fbf;
  localparam logic [13:0] WAKE_ALWAYS = 14'h003f;
  localparam logic [15:0] ADDR_RESET = 16'hfffe;
  localparam logic [15:0] ADDR_TRAP = 16'hfffc;
  localparam logic [15:0] ADDR_VEC0 = 16'hfffa;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic ien;
    logic idis;
    logic halt;
    logic wait_for_irq_instr;
    logic trap;
    logic service_return_instr;
    logic pop;
    logic [7:0] data;
  } nip_instr_s;

  typedef struct packed {
    logic vld;
    logic trap;
    logic [3:0] num;
    logic [15:0] addr;
  } nip_take_s;

  // Level order is not the code order: 10 < 01 < 00 < 11
  function automatic logic [2:0] code_level(input logic [1:0] c);
    case (c)
      2'b10: code_level = 3'h0;
      2'b01: code_level = 3'h1;
      2'b00: code_level = 3'h2;
      default: code_level = 3'h3;
    endcase
  endfunction : code_level

endpackage : nip_pkg

// *** nip_vpri_mem.sv ***
`timescale 1ns/1ns
`default_nettype none
module nip_vpri_mem (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Access port
  input wire logic we_i,
  input wire logic [1:0] idx_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // All fields for arbitration
  output logic [3:0][7:0] regs_o
);

  logic [3:0][7:0] mem_q;

  // ==========================================================
  // Storage, one register at a time
  for (genvar r = 0; r < 4; r++) begin : g_reg
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mem_q[r] <= nip_pkg::VPRI_RST; // RULE5
      end else if (we_i && idx_i == 2'(r)) begin
        for (int f = 0; f < 4; f++) begin
          // Level 0 code is refused per field, neighbours still load
          if (wdata_i[2*f+:2] != nip_pkg::CODE_L0 && !(r == 3 && f >= 2)) begin // RULE9 RULE6
            mem_q[r][2*f+:2] <= wdata_i[2*f+:2];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= mem_q[idx_i];
    end
  end

  assign regs_o = mem_q;

  // ==========================================================
  // Checks
  property p_l0_kept;
    @(posedge clk_i) disable iff (rst_i)
    we_i && wdata_i[1:0] == nip_pkg::CODE_L0 |=> mem_q[$past(idx_i)][1:0] == $past(mem_q[idx_i][1:0]);
  endproperty
  a_l0_kept: assert property (p_l0_kept) else $error("level 0 code was stored"); // RULE9

  property p_ro_upper;
    @(posedge clk_i) disable iff (rst_i)
    ##1 mem_q[3][7:4] == nip_pkg::VPRI3_RO[7:4];
  endproperty
  a_ro_upper: assert property (p_ro_upper) else $error("read-only bits changed"); // RULE6

endmodule : nip_vpri_mem
`default_nettype wire

// *** nip_core_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module nip_core_model (
  // Clock
  input wire logic clk_i,
  // Core side
  input wire nip_pkg::nip_take_s take_i,
  output var nip_pkg::nip_instr_s instr_o,
  output logic boundary_o,
  // Request sources
  output logic [13:0] req_o,
  output logic spi_slave_o,
  output logic pwm_ext_clk_o
);
  // ==========================================================
  // Strobes and request pulses
  nip_pkg::nip_take_s last_q;
  int takes;

  initial begin
    instr_o = '0;
    boundary_o = 1'b1;
    req_o = '0;
    spi_slave_o = 1'b0;
    pwm_ext_clk_o = 1'b0;
    takes = 0;
    last_q = '0;
  end

  task automatic strobe(input nip_pkg::nip_instr_s s);
    @(posedge clk_i);
    instr_o <= s;
    @(posedge clk_i);
    instr_o <= '0;
  endtask : strobe

  task automatic pulse(input logic [13:0] r);
    @(posedge clk_i);
    req_o <= r;
    @(posedge clk_i);
    req_o <= '0;
  endtask : pulse

  // Boundary low models a long multi-cycle instruction
  task automatic mode(input logic s, input logic p, input logic b);
    @(posedge clk_i);
    spi_slave_o <= s;
    pwm_ext_clk_o <= p;
    boundary_o <= b;
  endtask : mode

  // ==========================================================
  // Vector fetch log
  always @(posedge clk_i) begin
    if (take_i.vld === 1'b1) begin
      last_q <= take_i;
      takes <= takes + 1;
    end
  end
endmodule : nip_core_model
`default_nettype wire

// *** nested_interrupt_priority_unit_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module nested_interrupt_priority_unit_tb;
  // ==========================================================
  // Signals
  localparam int IEN = 0;
  localparam int IDIS = 1;
  localparam int WAIT_FOR_IRQ_INSTR = 3;
  localparam int TRAP = 4;
  localparam int SERVICE_RETURN_INSTR = 5;
  localparam int POP = 6;
  localparam int HALT = 2;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] d;
  logic ack, jm, jnm, hlt, wk, bnd, spi, pwm;
  logic [7:0] fl;
  logic [13:0] req;
  nip_pkg::nip_instr_s ins;
  nip_pkg::nip_take_s take;
  int err_count = 0;
  int check_count = 0;
  int seen = 0;
  int n;
  int ks[7] = '{IEN, IDIS, WAIT_FOR_IRQ_INSTR, POP, SERVICE_RETURN_INSTR, IDIS, HALT};
  logic [7:0] ds[7] = '{8'h00, 8'h00, 8'h00, 8'hc2, 8'hca, 8'h00, 8'h00};
  logic [1:0] cs[7] = '{2'b10, 2'b11, 2'b10, 2'b00, 2'b01, 2'b11, 2'b10};

  initial forever #20 clk = ~clk;

  nip_unit dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .instr_boundary_i(bnd), .instr_i(ins), .take_o(take), .cpu_flags_register_o(fl),
    .jump_if_masked_o(jm), .jump_if_unmasked_o(jnm), .halted_o(hlt), .wake_o(wk),
    .req_i(req), .spi_slave_i(spi), .pwm_ext_clk_i(pwm));

  nip_core_model core (.clk_i(clk), .take_i(take), .instr_o(ins), .boundary_o(bnd),
    .req_o(req), .spi_slave_o(spi), .pwm_ext_clk_o(pwm));

  // ==========================================================
  // Tasks
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask : wt

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  // Classic cycle: hold everything until ack is sampled high
  task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] v);
    int i;
    i = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    @(posedge clk);
    while (ack !== 1'b1 && i < 20) begin
      @(posedge clk);
      i++;
    end
    cmp("ack", 32'h1, {31'h0, ack});
    d = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : acc

  task automatic op(input int k, input logic [7:0] v);
    core.strobe(nip_pkg::nip_instr_s'({7'h40 >> k, v}));
  endtask : op

  task automatic lv(input logic [1:0] c);
    cmp("level", {30'h0, c}, {30'h0, fl[5], fl[3]});
    cmp("masked", {31'h0, &c}, {31'h0, jm});
    cmp("unmasked", {31'h0, ~&c}, {31'h0, jnm});
  endtask : lv

  // Waits for the next vector fetch and checks what was fetched
  task automatic tk(input logic t, input logic [3:0] v, input logic [1:0] c);
    int i;
    i = 0;
    seen++;
    while (core.takes < seen && i < 20) begin
      @(posedge clk);
      i++;
    end
    cmp("takes", seen, core.takes);
    cmp("trap", {31'h0, t}, {31'h0, core.last_q.trap});
    cmp("num", {28'h0, v}, {28'h0, core.last_q.num});
    cmp("addr", t ? 32'hfffc : 32'hfffa - 32'(2 * v), {16'h0, core.last_q.addr});
    lv(c);
  endtask : tk

  task automatic finish_test();
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  // ==========================================================
  // Tests
  initial begin
    wt(8);
    rst <= 1'b0;
    acc(0, 10'h080, 0);
    cmp("flags", 32'h0ea, d);
    lv(2'b11);
    for (int i = 0; i < 4; i++) begin
      acc(0, 10'h090 + 10'(4 * i), 0);
      cmp("vpri", 32'h0ff, d);
    end
    acc(1, 10'h09c, 0);
    acc(0, 10'h09c, 0);
    cmp("vpri3", 32'h0f0, d);
    acc(1, 10'h094, 32'h0cf);
    acc(1, 10'h094, 32'h064);
    acc(0, 10'h094, 0);
    cmp("vpri1", 32'h044, d);
    // Level 0 code alone, then a write without lane 0: neither may land
    acc(1, 10'h098, 32'h0fe);
    sel <= 4'he;
    acc(1, 10'h098, 32'h000);
    sel <= 4'hf;
    acc(0, 10'h098, 0);
    cmp("vpri2", 32'h0ff, d);
    acc(1, 10'h3fc, 32'h0ff);
    acc(0, 10'h3fc, 0);
    cmp("unmapped", 32'h0, d);
    for (int i = 0; i < 7; i++) begin
      op(ks[i], ds[i]);
      wt(1);
      lv(cs[i]);
    end
    // Timer, serial, voltage, two-wire and master-mode serial requests must not end halt
    core.pulse(14'h1dc0);
    wt(6);
    cmp("halted", 32'h1, {31'h0, hlt});
    acc(0, 10'h084, 0);
    cmp("pend", 32'h1d80, d);
    acc(1, 10'h084, 32'h3fff);
    core.mode(1'b0, 1'b1, 1'b1);
    core.pulse(14'h2000);
    n = 0;
    while (hlt !== 1'b0 && n < 10) begin
      @(posedge clk);
      n++;
    end
    cmp("wake", 32'h1, {31'h0, wk});
    tk(0, 13, 2'b00);
    op(IEN, 0);
    acc(1, 10'h090, 32'h0df);
    core.mode(1'b0, 1'b0, 1'b0);
    core.pulse(14'h0004);
    wt(4);
    cmp("takes", seen, core.takes);
    core.mode(1'b0, 1'b0, 1'b1);
    tk(0, 2, 2'b01);
    core.pulse(14'h0008);
    tk(0, 3, 2'b11);
    core.pulse(14'h0004);
    op(SERVICE_RETURN_INSTR, 8'hca);
    wt(4);
    cmp("takes", seen, core.takes);
    op(SERVICE_RETURN_INSTR, 8'he2);
    tk(0, 2, 2'b01);
    acc(1, 10'h094, 32'h0fc);
    op(IEN, 0);
    core.pulse(14'h0310);
    tk(0, 8, 2'b11);
    op(SERVICE_RETURN_INSTR, 8'he2);
    tk(0, 9, 2'b11);
    op(SERVICE_RETURN_INSTR, 8'he2);
    tk(0, 4, 2'b00);
    // Pending again at its own level, then raised while running
    core.pulse(14'h0010);
    acc(1, 10'h094, 32'h0ff);
    tk(0, 4, 2'b11);
    op(IDIS, 0);
    op(TRAP, 0);
    tk(1, 0, 2'b11);
    acc(1, 10'h090, 32'h0dc);
    core.pulse(14'h0001);
    tk(0, 0, 2'b11);
    // Serial peripheral as slave may end halt
    core.mode(1'b1, 1'b0, 1'b1);
    op(HALT, 0);
    core.pulse(14'h0080);
    tk(0, 7, 2'b11);
    cmp("halted", 32'h0, {31'h0, hlt});
    finish_test();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    wt(5000);
    err_count++;
    finish_test();
  end
endmodule : nested_interrupt_priority_unit_tb
`default_nettype wire
